// ===== rtl/pcs_pkg.sv
// Shared constants and types for the peripheral and cipher setup command block
package pcs_pkg;

	// ==========================================================================
	// Command codes
	localparam logic [7:0] CMD_CMP_OFF = 8'h0F;
	localparam logic [7:0] CMD_PWM     = 8'h10;
	localparam logic [7:0] CMD_IV      = 8'h11;
	localparam logic [7:0] CMD_KEY     = 8'h12;

	// ==========================================================================
	// Argument layout
	localparam logic [4:0] ARG_PIN     = 5'h00;
	localparam logic [4:0] ARG_DUTY    = 5'h01;
	localparam logic [4:0] ARG_FMT     = 5'h02;
	localparam logic [4:0] ARG_VAL     = 5'h03;
	localparam logic [4:0] PWM_ARG_LEN = 5'h07;
	localparam logic [4:0] VEC_LEN     = 5'h10;
	localparam logic [4:0] ARG_CNT_MAX = 5'h1F;

	// ==========================================================================
	// Value limits
	localparam logic [7:0] DUTY_MIN    = 8'h01;
	localparam logic [7:0] DUTY_MAX    = 8'h63;
	localparam logic [7:0] FMT_MAX     = 8'h03;
	localparam logic [7:0] NUM_PWM     = 8'h04;
	localparam logic [3:0] PAD_NONE    = 4'h0;
	localparam logic [3:0] PAD_WORD    = 4'hC;

	// ==========================================================================
	// Cipher store layout: vector bytes first, key bytes after
	localparam logic [4:0] IV_BASE     = 5'h00;
	localparam logic [4:0] KEY_BASE    = 5'h10;

	// ==========================================================================
	// Reset values
	localparam logic [7:0]  RST_DUTY   = 8'h00;
	localparam logic [31:0] RST_VALUE  = 32'h0000_0000;
	localparam logic [3:0]  RST_ACTIVE = 4'h0;

	// ==========================================================================
	// Timing
	localparam int CLK_HZ        = 32'h0131_2D00;
	localparam int SETTLE_MS     = 32'h0000_0032;
	localparam int MS_PER_S      = 32'h0000_03E8;
	localparam int SETTLE_CYCLES = CLK_HZ / MS_PER_S * SETTLE_MS;

	// ==========================================================================
	// Types
	typedef enum logic [1:0] {
		FMT_UINT_HZ = 2'h0,
		FMT_FLT_HZ  = 2'h1,
		FMT_UINT_US = 2'h2,
		FMT_FLT_S   = 2'h3
	} pcs_fmt_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARGS = 2'b01,
		ST_EXEC = 2'b11
	} pcs_state_t;

endpackage : pcs_pkg

// ===== rtl/pcs_keymem.sv
// Byte store for the cipher vector and key with a registered read port
`timescale 1ns/100ps
module pcs_keymem (
	input  wire logic       mclk,
	input  wire logic       wr_en,
	input  wire logic [4:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic [4:0] rd_addr,
	output logic      [7:0] rd_data
);
	logic [7:0] mem [0:31];

	// ==========================================================================
	// Write port; contents are not reset, software loads them before use
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// ==========================================================================
	// Registered read keeps the cipher path off a long combinational mux
	always_ff @(posedge mclk) begin
		rd_data <= mem[rd_addr];
	end
endmodule : pcs_keymem

// ===== rtl/pcs_cmd.sv
// Command interpreter for comparator shutdown, PWM setup and cipher vector/key
`timescale 1ns/100ps
//
// Operation
// [R1] Shutdown command turns comparator off, bare ACK
// [R2] PWM args: pin, duty, format, 4-byte value
// [R3] Pin index from zero, below channel count
// [R4] Duty valid only 1 to 99 percent
// [R5] Format codes: uint Hz, float Hz, uint us, float s
// [R6] PWM ACK carries four achieved value bytes
// [R7] Only pin-state command stops a PWM output
// [R8] Vector is sixteen bytes, least significant first
// [R9] Link cipher shares the tag-side AES-128 engine
// [R10] Cipher data padded to sixteen-byte multiples
// [R11] Vector replaced, ACK encrypted under new vector
// [R12] Key replaced, ACK encrypted under new key
// [R13] Host waits 50 ms after vector/key ACK
// [R14] Bad duty or format gives error, no change
module pcs_cmd #(
	parameter int SETTLE_CYCLES = pcs_pkg::SETTLE_CYCLES
) (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              pkt_valid,
	input  wire logic              pkt_first,
	input  wire logic              pkt_last,
	input  wire logic [7:0]        pkt_byte,
	input  wire logic              enc_mode,
	input  wire logic              comp_enable_req,
	input  wire logic              io_state_req,
	input  wire logic [1:0]        io_state_pin,
	input  wire logic [4:0]        key_rd_addr,
	output logic      [7:0]        key_rd_data,
	output logic                   comp_on,
	output logic      [3:0]        pwm_active,
	output logic      [1:0]        pwm_pin,
	output logic      [7:0]        pwm_duty,
	output pcs_pkg::pcs_fmt_t      pwm_format,
	output logic                   pwm_is_period,
	output logic                   pwm_is_float,
	output logic      [31:0]       pwm_value,
	output logic                   pwm_cfg_stb,
	output logic                   rsp_valid,
	output logic                   rsp_ack,
	output logic                   rsp_has_data,
	output logic      [31:0]       rsp_data,
	output logic                   rsp_encrypt,
	output logic      [3:0]        rsp_pad_len,
	output logic                   settle_busy
);
	import pcs_pkg::*;

	pcs_state_t  state_reg;
	logic [7:0]  cmd_reg;
	logic [4:0]  cnt_reg;
	logic [7:0]  pin_arg_reg;
	logic [7:0]  duty_arg_reg;
	logic [7:0]  fmt_arg_reg;
	logic [31:0] val_arg_reg;
	logic [19:0] settle_reg;
	logic        pwm_ok;
	logic        vec_ok;
	logic        exec_pwm;
	logic        exec_vec;
	logic        exec_off;
	logic        mem_wr;
	logic [4:0]  mem_addr;

	// ==========================================================================
	// Argument checks, evaluated once the packet has ended
	assign pwm_ok   = (cnt_reg == PWM_ARG_LEN) && (pin_arg_reg < NUM_PWM)     // R2 R3
		&& (duty_arg_reg >= DUTY_MIN) && (duty_arg_reg <= DUTY_MAX)        // R4 R14
		&& (fmt_arg_reg <= FMT_MAX);                                        // R5 R14
	assign vec_ok   = (cnt_reg == VEC_LEN);                                  // R8
	assign exec_pwm = (state_reg == ST_EXEC) && (cmd_reg == CMD_PWM);
	assign exec_vec = (state_reg == ST_EXEC) && ((cmd_reg == CMD_IV) || (cmd_reg == CMD_KEY));
	assign exec_off = (state_reg == ST_EXEC) && (cmd_reg == CMD_CMP_OFF);

	// ==========================================================================
	// Packet sequencing: command byte, arguments, one execute cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cmd_reg   <= 8'h00;
			cnt_reg   <= 5'h00;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (pkt_valid && pkt_first) begin
						cmd_reg   <= pkt_byte;
						cnt_reg   <= 5'h00;
						state_reg <= pkt_last ? ST_EXEC : ST_ARGS;
					end
				end
				ST_ARGS: begin
					if (pkt_valid && pkt_first) begin
						cmd_reg   <= pkt_byte;
						cnt_reg   <= 5'h00;
						state_reg <= pkt_last ? ST_EXEC : ST_ARGS;
					end else if (pkt_valid) begin
						// Saturate so an overlong packet still fails the length check
						if (cnt_reg != ARG_CNT_MAX) begin
							cnt_reg <= cnt_reg + 5'h01;
						end
						if (pkt_last) begin
							state_reg <= ST_EXEC;
						end
					end
				end
				ST_EXEC: begin
					state_reg <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================================
	// Capture PWM arguments; the timing value arrives low byte first
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_arg_reg  <= 8'h00;
			duty_arg_reg <= 8'h00;
			fmt_arg_reg  <= 8'h00;
			val_arg_reg  <= RST_VALUE;
		end else if (state_reg == ST_ARGS && pkt_valid && !pkt_first && cmd_reg == CMD_PWM) begin
			case (cnt_reg)
				ARG_PIN:  pin_arg_reg  <= pkt_byte;                            // R2
				ARG_DUTY: duty_arg_reg <= pkt_byte;                            // R2
				ARG_FMT:  fmt_arg_reg  <= pkt_byte;                            // R2
				ARG_VAL:          val_arg_reg[7:0]   <= pkt_byte;              // R2
				ARG_VAL + 5'h01:  val_arg_reg[15:8]  <= pkt_byte;
				ARG_VAL + 5'h02:  val_arg_reg[23:16] <= pkt_byte;
				ARG_VAL + 5'h03:  val_arg_reg[31:24] <= pkt_byte;
				default:  val_arg_reg <= val_arg_reg;
			endcase
		end
	end

	// ==========================================================================
	// Vector and key bytes go straight to the store as they arrive
	assign mem_wr   = (state_reg == ST_ARGS) && pkt_valid && !pkt_first
		&& ((cmd_reg == CMD_IV) || (cmd_reg == CMD_KEY)) && (cnt_reg < VEC_LEN);
	assign mem_addr = ((cmd_reg == CMD_KEY) ? KEY_BASE : IV_BASE) + {1'b0, cnt_reg[3:0]}; // R8 R12

	// Shared with the tag-side cipher through the read port
	pcs_keymem u_keymem (                                                       // R9
		.mclk    (mclk),
		.wr_en   (mem_wr),
		.wr_addr (mem_addr),
		.wr_data (pkt_byte),
		.rd_addr (key_rd_addr),
		.rd_data (key_rd_data)
	);

	// ==========================================================================
	// Comparator power; shutdown wins only when no enable arrives with it
	always_ff @(posedge mclk) begin
		if (rst) begin
			comp_on <= 1'b0;
		end else if (comp_enable_req) begin
			comp_on <= 1'b1;
		end else if (exec_off && cnt_reg == 5'h00) begin
			comp_on <= 1'b0;                                                   // R1
		end
	end

	// ==========================================================================
	// PWM configuration, held until the next accepted setup
	always_ff @(posedge mclk) begin
		if (rst) begin
			pwm_pin       <= 2'h0;
			pwm_duty      <= RST_DUTY;
			pwm_format    <= FMT_UINT_HZ;
			pwm_is_period <= 1'b0;
			pwm_is_float  <= 1'b0;
			pwm_value     <= RST_VALUE;
			pwm_cfg_stb   <= 1'b0;
		end else begin
			pwm_cfg_stb <= exec_pwm && pwm_ok;
			if (exec_pwm && pwm_ok) begin                                      // R14
				pwm_pin       <= pin_arg_reg[1:0];                             // R3
				pwm_duty      <= duty_arg_reg;                                 // R4
				pwm_format    <= pcs_fmt_t'(fmt_arg_reg[1:0]);                 // R5
				pwm_is_period <= fmt_arg_reg[1];                               // R5
				pwm_is_float  <= fmt_arg_reg[0];                               // R5
				pwm_value     <= val_arg_reg;
			end
		end
	end

	// ==========================================================================
	// Per-channel run flags: setup starts, pin-state stops, start wins a tie
	genvar ch;
	generate
		for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
			always_ff @(posedge mclk) begin
				if (rst) begin
					pwm_active[ch] <= RST_ACTIVE[ch];
				end else if (exec_pwm && pwm_ok && pin_arg_reg[1:0] == 2'(ch)) begin
					pwm_active[ch] <= 1'b1;
				end else if (io_state_req && io_state_pin == 2'(ch)) begin
					pwm_active[ch] <= 1'b0;                                    // R7
				end
			end
		end
	endgenerate

	// ==========================================================================
	// Reply; the achieved value echoes the request as the engine runs it
	always_ff @(posedge mclk) begin
		if (rst) begin
			rsp_valid    <= 1'b0;
			rsp_ack      <= 1'b0;
			rsp_has_data <= 1'b0;
			rsp_data     <= RST_VALUE;
			rsp_encrypt  <= 1'b0;
			rsp_pad_len  <= PAD_NONE;
		end else begin
			rsp_valid <= exec_pwm || exec_vec || exec_off;
			if (exec_pwm) begin
				rsp_ack      <= pwm_ok;                                        // R6 R14
				rsp_has_data <= pwm_ok;                                        // R6
				rsp_data     <= pwm_ok ? val_arg_reg : RST_VALUE;
				rsp_pad_len  <= pwm_ok ? PAD_WORD : PAD_NONE;                  // R10
			end else if (exec_vec || exec_off) begin
				rsp_ack      <= exec_vec ? vec_ok : (cnt_reg == 5'h00);        // R1 R11 R12
				rsp_has_data <= 1'b0;
				rsp_data     <= RST_VALUE;
				rsp_pad_len  <= PAD_NONE;                                      // R10
			end
			// Store is already written, so this reply uses the new settings
			rsp_encrypt <= enc_mode;                                           // R11 R12
		end
	end

	// ==========================================================================
	// Settling window after a vector or key change; host must stay quiet
	always_ff @(posedge mclk) begin
		if (rst) begin
			settle_reg  <= 20'h0_0000;
			settle_busy <= 1'b0;
		end else if (exec_vec && vec_ok) begin
			settle_reg  <= 20'(SETTLE_CYCLES - 1);                             // R13
			settle_busy <= 1'b1;
		end else if (settle_reg != 20'h0_0000) begin
			settle_reg  <= settle_reg - 20'h0_0001;
		end else begin
			settle_busy <= 1'b0;
		end
	end

	// ==========================================================================
	// Checks
	cmp_off_a: assert property (@(posedge mclk) disable iff (rst) // R1
		exec_off && cnt_reg == 5'h00 && !comp_enable_req
		|=> !comp_on && rsp_valid && rsp_ack && !rsp_has_data)
		else $error("comparator shutdown not applied");
	pwm_reply_a: assert property (@(posedge mclk) disable iff (rst) // R6
		exec_pwm && pwm_ok |=> rsp_valid && rsp_ack && rsp_has_data
		&& rsp_data == $past(val_arg_reg) && pwm_cfg_stb)
		else $error("pwm ack without value");
	duty_range_a: assert property (@(posedge mclk) disable iff (rst) // R4
		pwm_cfg_stb |-> pwm_duty >= DUTY_MIN && pwm_duty <= DUTY_MAX)
		else $error("duty out of range applied");
	pin_run_a: assert property (@(posedge mclk) disable iff (rst) // R3
		pwm_cfg_stb |-> pwm_active[pwm_pin])
		else $error("configured pin not running");
	fmt_decode_a: assert property (@(posedge mclk) disable iff (rst) // R5
		pwm_cfg_stb |-> pwm_is_period == (pwm_format == FMT_UINT_US || pwm_format == FMT_FLT_S)
		&& pwm_is_float == (pwm_format == FMT_FLT_HZ || pwm_format == FMT_FLT_S))
		else $error("format decode wrong");
	pwm_stop_a: assert property (@(posedge mclk) disable iff (rst) // R7
		io_state_req && !(exec_pwm && pwm_ok) |=> !pwm_active[$past(io_state_pin)])
		else $error("pin state did not stop pwm");
	vec_ack_a: assert property (@(posedge mclk) disable iff (rst) // R11
		exec_vec && vec_ok |=> rsp_valid && rsp_ack && !rsp_has_data
		&& rsp_encrypt == $past(enc_mode) && settle_busy)
		else $error("vector or key ack wrong");
	pwm_reject_a: assert property (@(posedge mclk) disable iff (rst) // R14
		exec_pwm && !pwm_ok |=> rsp_valid && !rsp_ack && $stable(pwm_duty) && !pwm_cfg_stb)
		else $error("bad pwm setup not refused");
	pad_len_a: assert property (@(posedge mclk) disable iff (rst) // R10
		rsp_valid |-> rsp_pad_len == (rsp_has_data ? PAD_WORD : PAD_NONE))
		else $error("pad length wrong");
	settle_hold_a: assert property (@(posedge mclk) disable iff (rst) // R13
		$rose(settle_busy) && SETTLE_CYCLES > 8 |-> settle_busy [*8])
		else $error("settle window too short");
endmodule : pcs_cmd

// ===== verif/pcs_host.sv
// Host-side model that sends command packets byte by byte
`timescale 1ns/100ps
module pcs_host (
	input  wire logic       mclk,
	input  wire logic       settle_busy,
	output logic            pkt_valid,
	output logic            pkt_first,
	output logic            pkt_last,
	output logic      [7:0] pkt_byte
);
	// ==========================================================================
	// Idle state of the byte lines
	initial begin
		pkt_valid = 1'b0;
		pkt_first = 1'b0;
		pkt_last  = 1'b0;
		pkt_byte  = 8'h00;
	end

	// ==========================================================================
	// Packet sender; slow mode inserts random gaps between bytes
	task automatic send(input logic [7:0] b[$], input bit slow);
		int n;
		n = 0;
		while (settle_busy === 1'b1 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		foreach (b[i]) begin
			@(negedge mclk);
			pkt_valid = 1'b1;
			pkt_first = (i == 0);
			pkt_last  = (i == b.size() - 1);
			pkt_byte  = b[i];
			@(negedge mclk);
			pkt_valid = 1'b0;
			pkt_first = 1'b0;
			pkt_last  = 1'b0;
			pkt_byte  = ~b[i]; // Stale data never mirrors the last byte
			if (slow)
				repeat ($urandom_range(0, 3)) @(negedge mclk);
		end
	endtask : send
endmodule : pcs_host

// ===== verif/peripheral_and_cipher_setup_commands_test.sv
// Self-checking testbench for the setup command interpreter
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module peripheral_and_cipher_setup_commands_test;
	import pcs_pkg::*;
	logic        mclk = 0, rst = 1, enc_mode = 0, comp_enable_req = 0, io_state_req = 0;
	logic        pkt_valid, pkt_first, pkt_last, comp_on, pwm_is_period, pwm_is_float;
	logic        pwm_cfg_stb, rsp_valid, rsp_ack, rsp_has_data, rsp_encrypt, settle_busy;
	logic [7:0]  pkt_byte, key_rd_data, pwm_duty;
	logic [1:0]  io_state_pin = 0, pwm_pin;
	logic [4:0]  key_rd_addr = 0;
	logic [3:0]  pwm_active, rsp_pad_len, r_pad, act_exp = 0;
	logic [31:0] pwm_value, rsp_data, r_data;
	logic        r_ack, r_has, r_enc;
	pcs_fmt_t    pwm_format;
	logic [7:0]  q[$];
	int          n_fail = 0, cmp_count = 0, rsp_cnt = 0, stb_cnt = 0;

	// ==========================================================================
	// Clock, partner and design
	always #25 mclk = ~mclk;
	pcs_host host (.mclk(mclk), .settle_busy(settle_busy), .pkt_valid(pkt_valid),
		.pkt_first(pkt_first), .pkt_last(pkt_last), .pkt_byte(pkt_byte));
	pcs_cmd #(.SETTLE_CYCLES(20)) dut (.mclk(mclk), .rst(rst), .pkt_valid(pkt_valid),
		.pkt_first(pkt_first), .pkt_last(pkt_last), .pkt_byte(pkt_byte),
		.enc_mode(enc_mode), .comp_enable_req(comp_enable_req), .io_state_req(io_state_req),
		.io_state_pin(io_state_pin), .key_rd_addr(key_rd_addr), .key_rd_data(key_rd_data),
		.comp_on(comp_on), .pwm_active(pwm_active), .pwm_pin(pwm_pin), .pwm_duty(pwm_duty),
		.pwm_format(pwm_format), .pwm_is_period(pwm_is_period), .pwm_is_float(pwm_is_float),
		.pwm_value(pwm_value), .pwm_cfg_stb(pwm_cfg_stb), .rsp_valid(rsp_valid),
		.rsp_ack(rsp_ack), .rsp_has_data(rsp_has_data), .rsp_data(rsp_data),
		.rsp_encrypt(rsp_encrypt), .rsp_pad_len(rsp_pad_len), .settle_busy(settle_busy));

	// Reply capture; fields are only meaningful in the strobe cycle
	always @(posedge mclk) begin
		// Apply strobes are counted so a missing or doubled one shows up
		if (pwm_cfg_stb === 1'b1)
			stb_cnt++;
		if (rsp_valid === 1'b1) begin
			rsp_cnt++;
			{r_ack, r_has, r_enc, r_data, r_pad} =
				{rsp_ack, rsp_has_data, rsp_encrypt, rsp_data, rsp_pad_len};
		end
	end

	// ==========================================================================
	// Shared tasks
	task automatic run(input bit slow, input int n_exp);
		int c0;
		c0 = rsp_cnt;
		host.send(q, slow);
		repeat (6) @(negedge mclk);
		`CHK(rsp_cnt - c0, n_exp)
	endtask : run

	task automatic pwm(input logic [7:0] pin, duty, fmt, input logic [31:0] v);
		logic ok;
		logic [7:0] od;
		logic [31:0] ov;
		int s0;
		s0 = stb_cnt;
		ok = pin < 4 && duty >= 1 && duty <= 99 && fmt <= 3;
		od = pwm_duty;
		ov = pwm_value;
		q = {CMD_PWM, pin, duty, fmt, v[7:0], v[15:8], v[23:16], v[31:24]};
		run(1, 1);
		`CHK(r_ack, ok)
		`CHK(stb_cnt - s0, int'(ok))
		if (ok) begin
			act_exp[pin[1:0]] = 1'b1;
			`CHK(pwm_pin, pin[1:0])
			`CHK(pwm_duty, duty)
			`CHK(pwm_format, pcs_fmt_t'(fmt[1:0]))
			`CHK({pwm_is_period, pwm_is_float}, fmt[1:0])
			`CHK(pwm_value, v)
			`CHK({r_has, r_pad, r_data}, {1'b1, 4'hC, v})
		end else begin
			`CHK({pwm_duty, pwm_value}, {od, ov})
		end
		`CHK(pwm_active, act_exp)
	endtask : pwm

	task automatic vec(input logic [4:0] base, input logic [7:0] cmd);
		logic [7:0] e[16];
		q = {cmd};
		foreach (e[k]) begin
			e[k] = 8'($urandom);
			q.push_back(e[k]);
		end
		run(0, 1);
		`CHK({r_ack, r_has, r_enc}, {2'b10, enc_mode})
		`CHK(settle_busy, 1'b1)
		foreach (e[k]) begin
			key_rd_addr = base + 5'(k);
			@(negedge mclk);
			`CHK(key_rd_data, e[k])
		end
		$display("test vector or key at base %h done", base);
	endtask : vec

	task automatic complete_run;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	// ==========================================================================
	// Watchdog at 20000 cycles, far beyond the roughly one thousand cycles the tests need
	initial begin
		#(50 * 20000);
		n_fail++;
		$display("watchdog expired");
		complete_run;
	end

	// ==========================================================================
	// Main sequence
	initial begin
		void'($urandom(89));
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		// Comparator shutdown, then a shutdown with a stray byte
		comp_enable_req = 1'b1;
		@(negedge mclk);
		comp_enable_req = 1'b0;
		q = {CMD_CMP_OFF};
		run(0, 1);
		`CHK({r_ack, r_has, comp_on}, 3'b100)
		comp_enable_req = 1'b1;
		@(negedge mclk);
		comp_enable_req = 1'b0;
		q = {CMD_CMP_OFF, 8'h00};
		run(0, 1);
		`CHK({r_ack, comp_on}, 2'b01)
		$display("test comparator done");
		// Every format, duty boundaries, then refusals and random mixes
		for (int f = 0; f < 4; f++)
			pwm(8'($urandom % 4), 8'(1 + $urandom % 99), 8'(f), $urandom);
		pwm(8'h00, 8'h01, 8'h02, 32'h0000_0001);
		pwm(8'h03, 8'h63, 8'h03, 32'hFFFF_FFFF);
		pwm(8'h01, 8'h00, 8'h00, 32'h0000_1234);
		pwm(8'h01, 8'h64, 8'h00, 32'h0000_1234);
		pwm(8'h02, 8'h32, 8'h04, 32'h0000_1234);
		pwm(8'h04, 8'h32, 8'h00, 32'h0000_1234);
		repeat (10)
			pwm(8'($urandom % 5), 8'($urandom % 110), 8'($urandom % 5), $urandom);
		$display("test pwm setup done");
		// Only the pin-state request stops a channel
		io_state_pin = pwm_pin;
		io_state_req = 1'b1;
		act_exp[pwm_pin] = 1'b0;
		@(negedge mclk);
		io_state_req = 1'b0;
		repeat (2) @(negedge mclk);
		`CHK(pwm_active, act_exp)
		// Unknown code gets no reply
		q = {8'h13};
		run(0, 0);
		// Short key packet: error reply and no settling window
		q = {CMD_KEY, 8'h00};
		run(0, 1);
		`CHK({r_ack, r_has, settle_busy}, 3'b000)
		$display("test stop and unknown done");
		vec(IV_BASE, CMD_IV);
		enc_mode = 1'b1;
		vec(KEY_BASE, CMD_KEY);
		enc_mode = 1'b0;
		complete_run;
	end
endmodule : peripheral_and_cipher_setup_commands_test
